// [verilog/sscr_regs.sv]
// What this block does
// R1: Value and condition register per terminal
// R2: Fault replaces value with fixed code
// R3: No sensor: code 0, 0x7FFF/0x8200
// R4: Normal: code 1, real measurement
// R5: Shorted: code 3, value 0x8000
// R6: Open: code 2, value 0x8100
// R7: Above range: code 4, value 0x8300
// R8: Below range: code 5, value 0x8400
// R9: Inconsistent: code 6, value 0x8500
// R10: Never report 0x8FFF as temperature
// R11: Dual safety inputs combine two terminals
// R12: Change registers clear after read
// R13: Status change flags, bits 15-11 one
// R14: Config change flags, bit 13 reserved
// R15: Live digital I/O bit register
// R16: Flag set when group value changes
// R17: Everything read-only 16-bit holding registers
// R18: Same-cycle event survives the clearing read
`timescale 1ns/1ps
`default_nettype none

module sscr_regs #(
	parameter int NUM_CH = 6,
	parameter logic [15:0] DUAL_TOL = sscr_pkg::DUAL_TOL_DFLT,
	parameter bit NONE_USES_B = 1'b0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic rd_hit,
	input wire logic [2*NUM_CH-1:0] sens_cfg,
	input wire logic [16*NUM_CH-1:0] sens_meas_a,
	input wire logic [16*NUM_CH-1:0] sens_meas_b,
	input wire logic [4*NUM_CH-1:0] sens_flt_a,
	input wire logic [4*NUM_CH-1:0] sens_flt_b,
	input wire logic [10:0] stat_evt,
	input wire logic [15:0] cfg_evt,
	input wire logic pump_a,
	input wire logic pump_b,
	input wire logic pump_c,
	input wire logic blower_motor,
	input wire logic ext_ignition,
	input wire logic pilot_valve,
	input wire logic main_valve,
	input wire logic alarm,
	input wire logic main_interlock,
	input wire logic pre_ignition_interlock,
	input wire logic load_control_input,
	input wire logic low_fire_switch,
	input wire logic high_fire_switch,
	input wire logic thermostat_demand,
	input wire logic time_of_day,
	input wire logic safety_relay
);

	// ----------------------------------------------------------------
	// Channel address table
	// ----------------------------------------------------------------
	function automatic logic [15:0] sscr_val_addr(input int ch);
		case (ch)
			0: sscr_val_addr = sscr_pkg::ADDR_VAL_OUTLET;
			1: sscr_val_addr = sscr_pkg::ADDR_VAL_INLET;
			2: sscr_val_addr = sscr_pkg::ADDR_VAL_HOT_WATER;
			3: sscr_val_addr = sscr_pkg::ADDR_VAL_S5;
			4: sscr_val_addr = sscr_pkg::ADDR_VAL_STACK;
			default: sscr_val_addr = sscr_pkg::ADDR_VAL_S2;
		endcase
	endfunction : sscr_val_addr

	// ----------------------------------------------------------------
	// Sensor channels
	// ----------------------------------------------------------------
	// Reset to the word an unconfigured terminal gives, so only configured channels set the sensor flag after release
	localparam logic [15:0] VAL_RST = NONE_USES_B ? sscr_pkg::VAL_NONE_B : sscr_pkg::VAL_NONE_A;
	logic [15:0] val_r [NUM_CH];
	logic [2:0] st_r [NUM_CH];
	logic [NUM_CH-1:0] ch_chg;
	logic [NUM_CH-1:0] ch_val_hit;
	logic [NUM_CH-1:0] ch_st_hit;
	logic [15:0] ch_data [NUM_CH];

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			logic [15:0] val_nxt;
			logic [2:0] st_nxt;
			localparam logic [15:0] VAL_ADDR = sscr_val_addr(g);
			localparam logic [15:0] ST_ADDR = 16'(VAL_ADDR + sscr_pkg::ADDR_STATE_OFS);
			// R1 R2 value and condition pair
			sscr_sensor_fmt #(
				.DUAL_TOL(DUAL_TOL),
				.NONE_USES_B(NONE_USES_B)
			) u_fmt (
				.cfg(sens_cfg[2*g +: 2]),
				.meas_a(sens_meas_a[16*g +: 16]),
				.meas_b(sens_meas_b[16*g +: 16]),
				.flt_a(sens_flt_a[4*g +: 4]),
				.flt_b(sens_flt_b[4*g +: 4]),
				.value(val_nxt),
				.state(st_nxt)
			);
			always_ff @(posedge clk_sys or negedge arst_n)
			begin
				if (!arst_n)
				begin
					val_r[g] <= VAL_RST;
					st_r[g] <= sscr_pkg::ST_NONE;
				end
				else
				begin
					val_r[g] <= val_nxt;
					st_r[g] <= st_nxt;
				end
			end
			// R16 sensor group change
			assign ch_chg[g] = (val_nxt != val_r[g]) || (st_nxt != st_r[g]);
			assign ch_val_hit[g] = (rd_addr == VAL_ADDR);
			assign ch_st_hit[g] = (rd_addr == ST_ADDR);
			assign ch_data[g] = ch_val_hit[g] ? val_r[g] : (ch_st_hit[g] ? {13'h0000, st_r[g]} : 16'h0000);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Change flags and digital I/O
	// ----------------------------------------------------------------
	logic [10:0] stat_chg_r;
	logic [15:0] cfg_chg_r;
	logic [15:0] dio_r;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	// Strobes carry rd_en so an idle address bus never clears a flag
	wire logic rd_stat = rd_en && (rd_addr == sscr_pkg::ADDR_STAT_CHG);
	wire logic rd_cfg = rd_en && (rd_addr == sscr_pkg::ADDR_CFG_CHG);
	wire logic rd_dio = rd_en && (rd_addr == sscr_pkg::ADDR_DIO);

	// R16 any channel movement marks the sensor group
	wire logic sens_any_chg = |ch_chg;
	wire logic [10:0] stat_set = stat_evt | (11'(sens_any_chg) << sscr_pkg::STAT_BIT_SENSOR);
	wire logic [15:0] cfg_set = cfg_evt & sscr_pkg::CFG_CHG_MASK;
	// A lost answer loses its flags: the clear rides on the read edge itself
	// R12 R18 clear only what was returned, new sets win
	wire logic [10:0] stat_chg_nxt = (rd_stat ? 11'h000 : stat_chg_r) | stat_set;
	wire logic [15:0] cfg_chg_nxt = (rd_cfg ? 16'h0000 : cfg_chg_r) | cfg_set;
	// One registered snapshot, so all sixteen bits of a read come from one edge
	// R15 live input and output states
	wire logic [15:0] dio_nxt = {safety_relay, time_of_day, thermostat_demand, high_fire_switch,
		low_fire_switch, load_control_input, pre_ignition_interlock, main_interlock,
		alarm, main_valve, pilot_valve, ext_ignition, blower_motor, pump_c, pump_b, pump_a};

	// R13 R14 R16 flag registers and R15 digital I/O snapshot
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stat_chg_r <= sscr_pkg::CHG_RST[10:0];
			cfg_chg_r <= sscr_pkg::CHG_RST;
			dio_r <= 16'h0000;
		end
		else
		begin
			stat_chg_r <= stat_chg_nxt;
			cfg_chg_r <= cfg_chg_nxt;
			dio_r <= dio_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Channel hits are one-hot, so an OR tree serves as the mux
	logic [15:0] ch_mux;
	always_comb
	begin
		ch_mux = 16'h0000;
		for (int i = 0; i < NUM_CH; i++)
			ch_mux = ch_mux | ch_data[i];
	end

	wire logic addr_hit = rd_stat || rd_cfg || rd_dio || (|ch_val_hit) || (|ch_st_hit);
	// R13 reserved status bits read as one
	wire logic [15:0] stat_word = sscr_pkg::STAT_CHG_ONES | {5'h00, stat_chg_r};
	// R17 read-only holding registers, writes have no path
	wire logic [15:0] rd_mux = rd_stat ? stat_word :
		rd_cfg ? cfg_chg_r :
		rd_dio ? dio_r : ch_mux;

	logic [15:0] rd_data_r;
	logic rd_valid_r;
	logic rd_hit_r;
	// Data register keeps the last answer between reads
	wire logic [15:0] rd_data_nxt = rd_en ? rd_mux : rd_data_r;
	wire logic rd_hit_nxt = rd_en && addr_hit;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_r <= 16'h0000;
			rd_valid_r <= 1'b0;
			rd_hit_r <= 1'b0;
		end
		else
		begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_en;
			rd_hit_r <= rd_hit_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign rd_hit = rd_hit_r;

endmodule : sscr_regs

`default_nettype wire

// [verilog/sscr_pkg.sv]
package sscr_pkg;

	// ----------------------------------------------------------------
	// Holding register numbers
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_STAT_CHG = 16'h0000;
	localparam logic [15:0] ADDR_CFG_CHG = 16'h0001;
	localparam logic [15:0] ADDR_DIO = 16'h0002;
	localparam logic [15:0] ADDR_VAL_OUTLET = 16'h0007;
	localparam logic [15:0] ADDR_VAL_INLET = 16'h000B;
	localparam logic [15:0] ADDR_VAL_HOT_WATER = 16'h000C;
	localparam logic [15:0] ADDR_VAL_S5 = 16'h000D;
	localparam logic [15:0] ADDR_VAL_STACK = 16'h000E;
	localparam logic [15:0] ADDR_VAL_S2 = 16'h000F;
	// Condition register sits this far above its value register
	localparam logic [15:0] ADDR_STATE_OFS = 16'h0026;

	// ----------------------------------------------------------------
	// Change register layout and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] STAT_CHG_ONES = 16'hF800;
	localparam logic [15:0] CFG_CHG_MASK = 16'hDFFF;
	localparam logic [15:0] CHG_RST = 16'h0000;
	localparam int STAT_BIT_SENSOR = 2;
	localparam int STAT_GROUPS = 11;

	// ----------------------------------------------------------------
	// Terminal configuration and fault flag positions
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_NONE = 2'h0;
	localparam logic [1:0] CFG_SINGLE = 2'h1;
	localparam logic [1:0] CFG_DUAL = 2'h2;
	localparam logic [1:0] CFG_PRESSURE = 2'h3;
	localparam int FLT_SHORT = 0;
	localparam int FLT_OPEN = 1;
	localparam int FLT_HIGH = 2;
	localparam int FLT_LOW = 3;

	// ----------------------------------------------------------------
	// Sensor condition codes and substitute values
	// ----------------------------------------------------------------
	localparam logic [2:0] ST_NONE = 3'h0;
	localparam logic [2:0] ST_NORMAL = 3'h1;
	localparam logic [2:0] ST_OPEN = 3'h2;
	localparam logic [2:0] ST_SHORT = 3'h3;
	localparam logic [2:0] ST_HIGH = 3'h4;
	localparam logic [2:0] ST_LOW = 3'h5;
	localparam logic [2:0] ST_UNRELIABLE = 3'h6;
	localparam logic [15:0] VAL_NONE_A = 16'h7FFF;
	localparam logic [15:0] VAL_NONE_B = 16'h8200;
	localparam logic [15:0] VAL_SHORT = 16'h8000;
	localparam logic [15:0] VAL_OPEN = 16'h8100;
	localparam logic [15:0] VAL_HIGH = 16'h8300;
	localparam logic [15:0] VAL_LOW = 16'h8400;
	localparam logic [15:0] VAL_UNRELIABLE = 16'h8500;
	localparam logic [15:0] VAL_UNSET_CFG = 16'h8FFF;
	localparam logic [15:0] DUAL_TOL_DFLT = 16'h0032;

endpackage : sscr_pkg

// [verilog/sscr_sensor_fmt.sv]
`timescale 1ns/1ps
`default_nettype none

module sscr_sensor_fmt #(
	parameter logic [15:0] DUAL_TOL = sscr_pkg::DUAL_TOL_DFLT,
	parameter bit NONE_USES_B = 1'b0
) (
	input wire logic [1:0] cfg,
	input wire logic [15:0] meas_a,
	input wire logic [15:0] meas_b,
	input wire logic [3:0] flt_a,
	input wire logic [3:0] flt_b,
	output logic [15:0] value,
	output logic [2:0] state
);

	// ----------------------------------------------------------------
	// Fault merge
	// ----------------------------------------------------------------
	wire logic is_dual = (cfg == sscr_pkg::CFG_DUAL);
	// R11 dual pair
	wire logic [3:0] flt = flt_a | (is_dual ? flt_b : 4'h0);
	wire logic signed [16:0] diff = $signed({meas_a[15], meas_a}) - $signed({meas_b[15], meas_b});
	wire logic [16:0] diff_abs = diff[16] ? 17'(-diff) : 17'(diff);
	wire logic mismatch = is_dual && (diff_abs > {1'b0, DUAL_TOL});
	// Truncation of the pair average is fine at 0.1 degree steps
	wire logic signed [16:0] sum = $signed({meas_a[15], meas_a}) + $signed({meas_b[15], meas_b});
	wire logic [15:0] meas = is_dual ? sum[16:1] : meas_a;
	// R10 unset marker never reported
	wire logic unset_hit = (meas == sscr_pkg::VAL_UNSET_CFG);

	// ----------------------------------------------------------------
	// Priority encode, worst condition first
	// ----------------------------------------------------------------
	always_comb
	begin
		// R4 normal measurement
		value = meas;
		state = sscr_pkg::ST_NORMAL;
		if (cfg == sscr_pkg::CFG_NONE)
		begin
			// R3 no sensor
			value = NONE_USES_B ? sscr_pkg::VAL_NONE_B : sscr_pkg::VAL_NONE_A;
			state = sscr_pkg::ST_NONE;
		end
		else if (flt[sscr_pkg::FLT_SHORT])
		begin
			// R5 shorted
			value = sscr_pkg::VAL_SHORT;
			state = sscr_pkg::ST_SHORT;
		end
		else if (flt[sscr_pkg::FLT_OPEN])
		begin
			// R6 open
			value = sscr_pkg::VAL_OPEN;
			state = sscr_pkg::ST_OPEN;
		end
		else if (flt[sscr_pkg::FLT_HIGH])
		begin
			// R7 above range
			value = sscr_pkg::VAL_HIGH;
			state = sscr_pkg::ST_HIGH;
		end
		else if (flt[sscr_pkg::FLT_LOW])
		begin
			// R8 below range
			value = sscr_pkg::VAL_LOW;
			state = sscr_pkg::ST_LOW;
		end
		else if (mismatch || unset_hit)
		begin
			// R9 inconsistent readings
			value = sscr_pkg::VAL_UNRELIABLE;
			state = sscr_pkg::ST_UNRELIABLE;
		end
	end

endmodule : sscr_sensor_fmt

`default_nettype wire

// [bench/sscr_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sscr_regs_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_hit,
	input wire logic [10:0] stat_evt
);
	// ----
	// Read port
	// ----
	default clocking dcb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence stat_rd;
		rd_en && rd_addr == sscr_pkg::ADDR_STAT_CHG && stat_evt == 11'h000;
	endsequence
	AST_ANSWER: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	AST_QUIET: assert property (!rd_en |=> !rd_valid)
		else $error("answer without read");
	AST_STAT_ONES: assert property (rd_en && rd_addr == sscr_pkg::ADDR_STAT_CHG |=> rd_data[15:11] == 5'h1F)
		else $error("status top bits not ones");
	AST_CFG_RSVD: assert property (rd_en && rd_addr == sscr_pkg::ADDR_CFG_CHG |=> !rd_data[13])
		else $error("config reserved bit set");
	AST_REFUSE: assert property (rd_valid && !rd_hit |-> rd_data == 16'h0000)
		else $error("unmapped read gave data");
	AST_MISS: assert property (rd_en && rd_addr == 16'h0003 |=> rd_valid && !rd_hit)
		else $error("unmapped read reported hit");
	// Sensor bit left out: channel updates may set it at any time
	AST_CLEARED: assert property (stat_rd ##1 stat_evt == 11'h000 ##1 stat_rd |=> (rd_data & 16'h07FB) == 16'h0000)
		else $error("status flags survived read");
	AST_EVT_SEEN: assert property (stat_evt[0] ##1 rd_en && rd_addr == sscr_pkg::ADDR_STAT_CHG |=> rd_data[0])
		else $error("event flag missing");
	cover property (stat_rd);
	cover property (rd_en && rd_addr == sscr_pkg::ADDR_CFG_CHG);
	cover property (rd_valid && !rd_hit);
endmodule : sscr_regs_chk
bind sscr_regs sscr_regs_chk u_sscr_regs_chk (.clk_sys(clk_sys), .arst_n(arst_n), .rd_en(rd_en),
	.rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit), .stat_evt(stat_evt));
`default_nettype wire

// [bench/sscr_master.sv]
`timescale 1ns/1ps
`default_nettype none
module sscr_master (
	input wire logic clk_sys,
	output logic rd_en,
	output logic [15:0] rd_addr,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_hit
);
	// ----
	// Polling master
	// ----
	initial
	begin
		rd_en = 1'b0;
		rd_addr = 16'hFFFF;
	end
	task automatic rd(input logic [15:0] a, output logic [16:0] hd, output bit late);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk_sys);
		rd_en = 1'b0;
		rd_addr = ~a;
		late = (rd_valid !== 1'b1);
		hd = {rd_hit, rd_data};
		// Gap cycle so rd_en never toggles twice in one step
		@(negedge clk_sys);
	endtask : rd
endmodule : sscr_master
`default_nettype wire

// [bench/tb_sensor_status_change_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_status_change_regs;
	typedef struct packed {logic [1:0] cfg; logic [15:0] a; logic [15:0] b; logic [3:0] flt; logic [15:0] val;
		logic [2:0] st;} sscr_row_t;
	logic clk_sys, arst_n, rd_en, rd_valid, rd_hit;
	logic [15:0] rd_addr, rd_data, cfg_evt, dio;
	logic [11:0] sens_cfg;
	logic [95:0] sens_meas_a, sens_meas_b;
	logic [23:0] sens_flt_a, sens_flt_b;
	logic [10:0] stat_evt;
	int errors, n_compared;
	sscr_row_t rows [10] = '{
		'{2'h0, 16'h1234, 16'h0000, 4'h0, 16'h7FFF, 3'h0},
		'{2'h1, 16'h0123, 16'h0000, 4'h0, 16'h0123, 3'h1},
		'{2'h3, 16'h0096, 16'h0000, 4'h0, 16'h0096, 3'h1},
		'{2'h1, 16'h0123, 16'h0000, 4'h1, 16'h8000, 3'h3},
		'{2'h1, 16'h0123, 16'h0000, 4'h2, 16'h8100, 3'h2},
		'{2'h1, 16'h0123, 16'h0000, 4'h4, 16'h8300, 3'h4},
		'{2'h1, 16'h0123, 16'h0000, 4'h8, 16'h8400, 3'h5},
		'{2'h2, 16'h0064, 16'h0100, 4'h0, 16'h8500, 3'h6},
		'{2'h2, 16'h0100, 16'h0110, 4'h0, 16'h0108, 3'h1},
		'{2'h1, 16'h8FFF, 16'h0000, 4'h0, 16'h8500, 3'h6}};
	sscr_regs u_sscr_regs (.clk_sys(clk_sys), .arst_n(arst_n), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit), .sens_cfg(sens_cfg), .sens_meas_a(sens_meas_a),
		.sens_meas_b(sens_meas_b), .sens_flt_a(sens_flt_a), .sens_flt_b(sens_flt_b), .stat_evt(stat_evt),
		.cfg_evt(cfg_evt), .pump_a(dio[0]), .pump_b(dio[1]), .pump_c(dio[2]), .blower_motor(dio[3]),
		.ext_ignition(dio[4]), .pilot_valve(dio[5]), .main_valve(dio[6]), .alarm(dio[7]),
		.main_interlock(dio[8]), .pre_ignition_interlock(dio[9]), .load_control_input(dio[10]),
		.low_fire_switch(dio[11]), .high_fire_switch(dio[12]), .thermostat_demand(dio[13]),
		.time_of_day(dio[14]), .safety_relay(dio[15]));
	sscr_master u_sscr_master (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_hit(rd_hit));
	// ----
	// Helpers
	// ----
	always #5 clk_sys = ~clk_sys;
	task automatic close_out();
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Top bit is the answer arriving on time
	task automatic rw(input logic [15:0] a, input logic [15:0] ed, input logic eh);
		logic [16:0] hd;
		bit late;
		u_sscr_master.rd(a, hd, late);
		check({~late, hd}, {1'b1, eh, ed});
	endtask : rw
	// ----
	// Sequence
	// ----
	initial
	begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		{sens_cfg, sens_meas_a, sens_meas_b, sens_flt_a, sens_flt_b, stat_evt, cfg_evt, dio} = '0;
		repeat (5) @(negedge clk_sys);
		arst_n = 1'b1;
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF800, 1'b1);
		rw(sscr_pkg::ADDR_CFG_CHG, 16'h0000, 1'b1);
		dio = 16'hA5C3;
		@(negedge clk_sys);
		rw(sscr_pkg::ADDR_DIO, 16'hA5C3, 1'b1);
		dio = 16'h5A3C;
		@(negedge clk_sys);
		rw(sscr_pkg::ADDR_DIO, 16'h5A3C, 1'b1);
		for (int i = 0; i < 10; i++)
		begin
			sens_cfg[3:2] = rows[i].cfg;
			sens_meas_a[31:16] = rows[i].a;
			sens_meas_b[31:16] = rows[i].b;
			sens_flt_a[7:4] = rows[i].flt;
			@(negedge clk_sys);
			rw(sscr_pkg::ADDR_VAL_INLET, rows[i].val, 1'b1);
			rw(sscr_pkg::ADDR_VAL_INLET + sscr_pkg::ADDR_STATE_OFS, {13'h0000, rows[i].st}, 1'b1);
		end
		// Second terminal's fault only counts for a dual pair
		sens_cfg[3:2] = sscr_pkg::CFG_DUAL;
		sens_meas_a[31:16] = 16'h0100;
		sens_meas_b[31:16] = 16'h0100;
		sens_flt_a[7:4] = 4'h0;
		sens_flt_b[7:4] = 4'h2;
		@(negedge clk_sys);
		rw(sscr_pkg::ADDR_VAL_INLET, 16'h8100, 1'b1);
		sens_cfg[3:2] = sscr_pkg::CFG_SINGLE;
		@(negedge clk_sys);
		rw(sscr_pkg::ADDR_VAL_INLET, 16'h0100, 1'b1);
		// Last channel answers at its own pair of numbers, first stays unconfigured
		sens_cfg[11:10] = sscr_pkg::CFG_SINGLE;
		sens_meas_a[95:80] = 16'h00C8;
		@(negedge clk_sys);
		rw(sscr_pkg::ADDR_VAL_S2, 16'h00C8, 1'b1);
		rw(sscr_pkg::ADDR_VAL_S2 + sscr_pkg::ADDR_STATE_OFS, 16'h0001, 1'b1);
		rw(sscr_pkg::ADDR_VAL_OUTLET, 16'h7FFF, 1'b1);
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF804, 1'b1);
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF800, 1'b1);
		stat_evt = 11'h7FF;
		cfg_evt = 16'hFFFF;
		@(negedge clk_sys);
		stat_evt = 11'h000;
		cfg_evt = 16'h0000;
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hFFFF, 1'b1);
		rw(sscr_pkg::ADDR_CFG_CHG, 16'hDFFF, 1'b1);
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF800, 1'b1);
		rw(sscr_pkg::ADDR_CFG_CHG, 16'h0000, 1'b1);
		// Event lands on the clearing read's edge
		stat_evt = 11'h001;
		fork
			rw(sscr_pkg::ADDR_STAT_CHG, 16'hF800, 1'b1);
			begin
				@(negedge clk_sys);
				stat_evt = 11'h000;
			end
		join
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF801, 1'b1);
		// Mid-run reset drops pending flags and quiets the read port
		stat_evt = 11'h7FF;
		@(negedge clk_sys);
		stat_evt = 11'h000;
		arst_n = 1'b0;
		@(negedge clk_sys);
		check({rd_valid, rd_hit, rd_data}, 18'h00000);
		arst_n = 1'b1;
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF800, 1'b1);
		// Channel registers reload from live inputs and mark the sensor group
		rw(sscr_pkg::ADDR_STAT_CHG, 16'hF804, 1'b1);
		rw(16'h0003, 16'h0000, 1'b0);
		close_out();
	end
endmodule : tb_sensor_status_change_regs
`default_nettype wire
